// [lpctm_host.sv]
`timescale 1ns/1ps
`default_nettype none
// Host processor: drives the mode pins and reacts to the interrupt pins
module lpctm_host #(
    parameter int CURRENT_CHANNEL_GAIN = 1
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_b,
    // Mode command from the bench
    input wire logic cmd_valid,
    input wire logic [1:0] cmd_mode,
    // Interrupt pins
    input wire logic quiet_current_irq_n,
    input wire logic current_present_irq_n,
    // Mode pins
    output logic mode_select_msb,
    output logic mode_select_lsb
);
    logic gain_allows_low;

    // Low power is only asked for at a current gain of 1 or 2
    assign gain_allows_low = (CURRENT_CHANNEL_GAIN == 1) || (CURRENT_CHANNEL_GAIN == 2);

    // Pins move by non-blocking update on the rising edge; commands set at the falling edge
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            {mode_select_msb, mode_select_lsb} <= lpctm_pkg::MODE_NORMAL;
        end else if (cmd_valid && (cmd_mode != lpctm_pkg::MODE_LOW || gain_allows_low)) begin
            {mode_select_msb, mode_select_lsb} <= cmd_mode;
        end else if ({mode_select_msb, mode_select_lsb} == lpctm_pkg::MODE_LOW) begin
            if (!quiet_current_irq_n) begin
                {mode_select_msb, mode_select_lsb} <= lpctm_pkg::MODE_SLEEP;
            end else if (!current_present_irq_n) begin
                {mode_select_msb, mode_select_lsb} <= lpctm_pkg::MODE_REDUCED;
            end
        end
    end
endmodule // lpctm_host
`default_nettype wire

// [lpctm_monitor.sv]
`timescale 1ns/1ps
`default_nettype none
module lpctm_monitor #(
    parameter int SAMPLE_W = 16,
    parameter int COUNT_W = 8,
    parameter int WINDOW_UNIT = lpctm_pkg::WINDOW_UNIT_CYCLES
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic soft_reset,
    // Mode pins from the host
    input wire logic mode_select_msb,
    input wire logic mode_select_lsb,
    // Register access from the serial port core
    input wire logic threshold_write,
    input wire logic [7:0] threshold_wdata,
    input wire logic port_lock_write,
    input wire logic [7:0] port_lock_wdata,
    input wire logic status_write,
    input wire logic [15:0] status_wdata,
    input wire logic spi_select_request,
    // Current samples, positive terminals, and full scale
    input wire logic sample_valid,
    input wire logic [SAMPLE_W-1:0] phase_a_positive_input,
    input wire logic [SAMPLE_W-1:0] phase_b_positive_input,
    input wire logic [SAMPLE_W-1:0] phase_c_positive_input,
    input wire logic [SAMPLE_W-1:0] full_scale,
    // Register views
    output logic [7:0] low_power_current_threshold,
    output logic [7:0] port_lock_config,
    output logic [15:0] second_status_register,
    // Interrupt pins
    output logic quiet_current_irq_n,
    output logic current_present_irq_n,
    // Port and engine enables
    output logic serial_port_enable,
    output logic spi_selected,
    output logic high_speed_capture_port_enable,
    output logic general_regs_available,
    output logic mean_abs_enable,
    output logic dsp_idle,
    output lpctm_pkg::lpctm_mode_t power_mode
);
    localparam int WCNT_W = 32;
    logic [1:0] pins_meta;
    logic [1:0] pins_sync;
    lpctm_pkg::lpctm_mode_t next_mode;
    logic [WCNT_W-1:0] unit_count;
    logic [4:0] unit_index;
    logic window_start;
    logic window_end;
    logic in_low;
    logic [SAMPLE_W-1:0] threshold;
    logic [SAMPLE_W+2:0] threshold_wide;
    logic [COUNT_W-1:0] counts [3];
    logic [SAMPLE_W-1:0] samples [3];
    logic [COUNT_W-1:0] limit;
    logic any_present;
    logic transition_active;
    logic [4:0] transition_count;
    logic done_flag;
    logic done_set;
    logic done_clear;
    logic port_locked;

    // Mode pins pass two flip-flops; idle in normal mode
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            pins_meta <= lpctm_pkg::MODE_NORMAL;
            pins_sync <= lpctm_pkg::MODE_NORMAL;
        end else begin
            pins_meta <= {mode_select_msb, mode_select_lsb};
            pins_sync <= pins_meta;
        end
    end

    // Decode of the mode pins
    always_comb begin
        case (pins_sync)
            lpctm_pkg::MODE_NORMAL: next_mode = lpctm_pkg::LPCTM_NORMAL;
            lpctm_pkg::MODE_REDUCED: next_mode = lpctm_pkg::LPCTM_REDUCED;
            lpctm_pkg::MODE_LOW: next_mode = lpctm_pkg::LPCTM_LOW;
            lpctm_pkg::MODE_SLEEP: next_mode = lpctm_pkg::LPCTM_SLEEP;
            default: next_mode = lpctm_pkg::LPCTM_NORMAL;
        endcase
    end

    // Current power mode
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            power_mode <= lpctm_pkg::LPCTM_NORMAL;
        end else begin
            power_mode <= next_mode;
        end
    end

    // Enables per mode
    assign in_low = (power_mode == lpctm_pkg::LPCTM_LOW);
    assign serial_port_enable = (power_mode == lpctm_pkg::LPCTM_NORMAL)
        || (power_mode == lpctm_pkg::LPCTM_REDUCED);
    assign high_speed_capture_port_enable = (power_mode == lpctm_pkg::LPCTM_NORMAL);
    assign general_regs_available = (power_mode == lpctm_pkg::LPCTM_NORMAL)
        && !transition_active;
    assign mean_abs_enable = (power_mode == lpctm_pkg::LPCTM_NORMAL)
        || (power_mode == lpctm_pkg::LPCTM_REDUCED);
    assign dsp_idle = 1'b1;

    // Threshold register; software reset leaves it alone, writes only in normal mode
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            low_power_current_threshold <= lpctm_pkg::THRESHOLD_RESET;
        end else if (threshold_write && general_regs_available) begin
            low_power_current_threshold <= threshold_wdata;
        end
    end

    // Port lock register and serial port choice
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            port_lock_config <= lpctm_pkg::PORT_LOCK_RESET;
            port_locked <= 1'b0;
            spi_selected <= 1'b0;
        end else begin
            if (port_lock_write && general_regs_available) begin
                port_lock_config <= port_lock_wdata;
                if (spi_selected || port_lock_wdata[lpctm_pkg::LOCK_BIT]) begin
                    port_locked <= 1'b1;
                end
            end
            if (spi_select_request && !port_locked && general_regs_available) begin
                spi_selected <= 1'b1;
            end else if (soft_reset && !port_locked) begin
                spi_selected <= 1'b0;
            end
        end
    end

    // Threshold = full scale * level / 8
    assign threshold_wide = full_scale * low_power_current_threshold[lpctm_pkg::LEVEL_MSB:
        lpctm_pkg::LEVEL_LSB];
    assign threshold = threshold_wide[SAMPLE_W+2:lpctm_pkg::LEVEL_DIV_SHIFT];

    // Window timer: (field + 1) units of 0.02 s, restarting while in low power
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            unit_count <= '0;
            unit_index <= '0;
        end else if (!in_low || window_end) begin
            unit_count <= '0;
            unit_index <= '0;
        end else if (unit_count == WCNT_W'(WINDOW_UNIT - 1)) begin
            unit_count <= '0;
            unit_index <= unit_index + 1'b1;
        end else begin
            unit_count <= unit_count + 1'b1;
        end
    end

    assign window_end = in_low && (unit_count == WCNT_W'(WINDOW_UNIT - 1))
        && (unit_index == low_power_current_threshold[lpctm_pkg::WINDOW_MSB:
        lpctm_pkg::WINDOW_LSB]);
    assign window_start = !in_low || window_end;

    // One excursion counter per phase
    assign samples[0] = phase_a_positive_input;
    assign samples[1] = phase_b_positive_input;
    assign samples[2] = phase_c_positive_input;
    for (genvar p = 0; p < 3; p++) begin : g_phase
        lpctm_phase #(
            .SAMPLE_W(SAMPLE_W),
            .COUNT_W(COUNT_W)
        ) u_phase (
            .mclk(mclk),
            .rst_b(rst_b),
            .window_start(window_start),
            .sample_valid(sample_valid && in_low),
            .positive_sample(samples[p]),
            .threshold(threshold),
            .count(counts[p])
        );
    end

    // Period plus one compared with each counter
    assign limit = COUNT_W'(low_power_current_threshold[lpctm_pkg::WINDOW_MSB:
        lpctm_pkg::WINDOW_LSB]) + 1'b1;
    assign any_present = (counts[0] >= limit) || (counts[1] >= limit)
        || (counts[2] >= limit);

    // Transition into normal mode, then done flag
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            transition_active <= 1'b1;
            transition_count <= '0;
        end else if (power_mode != lpctm_pkg::LPCTM_NORMAL || soft_reset) begin
            transition_active <= 1'b1;
            transition_count <= '0;
        end else if (transition_active) begin
            if (transition_count == 5'(lpctm_pkg::TRANSITION_CYCLES - 1)) begin
                transition_active <= 1'b0;
            end
            transition_count <= transition_count + 1'b1;
        end
    end

    assign done_set = transition_active && power_mode == lpctm_pkg::LPCTM_NORMAL
        && !soft_reset && transition_count == 5'(lpctm_pkg::TRANSITION_CYCLES - 1);

    // Write of one to the done bit, taken only while registers are open
    assign done_clear = status_write && status_wdata[lpctm_pkg::DONE_BIT]
        && general_regs_available;

    // Done flag: cleared during transition, set at end, write one clears; set wins
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            done_flag <= 1'b0;
        end else if (done_set) begin
            done_flag <= 1'b1;
        end else if (transition_active) begin
            done_flag <= 1'b0;
        end else if (done_clear) begin
            done_flag <= 1'b0;
        end
    end

    assign second_status_register = {done_flag, 15'h0000};

    // Interrupt pins: window results latch until mode leaves low power
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            quiet_current_irq_n <= 1'b1;
            current_present_irq_n <= 1'b1;
        end else begin
            if (window_end && !any_present) begin
                quiet_current_irq_n <= 1'b0;
            end else if (!in_low) begin
                quiet_current_irq_n <= 1'b1;
            end
            if (window_end && any_present) begin
                current_present_irq_n <= 1'b0;
            end else if (done_set) begin
                current_present_irq_n <= 1'b0;
            end else if (power_mode == lpctm_pkg::LPCTM_NORMAL && (!done_flag || done_clear)) begin
                current_present_irq_n <= 1'b1;
            end else if (power_mode != lpctm_pkg::LPCTM_NORMAL && !in_low) begin
                current_present_irq_n <= 1'b1;
            end
        end
    end
endmodule // lpctm_monitor
`default_nettype wire

// [lpctm_monitor_props.sv]
`timescale 1ns/1ps
`default_nettype none
// Checker on the monitor's ports
module lpctm_monitor_props (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_b,
    // Inputs watched
    input wire logic soft_reset,
    input wire logic mode_select_msb,
    input wire logic mode_select_lsb,
    input wire logic status_write,
    input wire logic [15:0] status_wdata,
    // Outputs watched
    input wire logic [7:0] low_power_current_threshold,
    input wire logic [7:0] port_lock_config,
    input wire logic [15:0] second_status_register,
    input wire logic quiet_current_irq_n,
    input wire logic current_present_irq_n,
    input wire logic serial_port_enable,
    input wire logic high_speed_capture_port_enable,
    input wire logic general_regs_available,
    input wire logic mean_abs_enable,
    input wire lpctm_pkg::lpctm_mode_t power_mode
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_b);
    // Pins held at low power long enough to pass the synchroniser
    sequence s_pins_low;
        ({mode_select_msb, mode_select_lsb} == lpctm_pkg::MODE_LOW) [*4];
    endsequence
    // Host writes one to a set done flag
    sequence s_done_clear;
        status_write && status_wdata[15] && second_status_register[15] && general_regs_available;
    endsequence
    // Mode, port and register relations
    chk_pins_to_mode: assert property (s_pins_low |-> power_mode == lpctm_pkg::LPCTM_LOW)
        else $error("mode does not follow pins");
    chk_low_port_off: assert property (power_mode == lpctm_pkg::LPCTM_LOW |-> !serial_port_enable)
        else $error("serial port on in low power");
    chk_sleep_ports: assert property (power_mode == lpctm_pkg::LPCTM_SLEEP
        |-> !serial_port_enable && !high_speed_capture_port_enable) else $error("port on in sleep");
    chk_regs_gated: assert property (power_mode != lpctm_pkg::LPCTM_NORMAL
        |-> !general_regs_available) else $error("registers open outside normal");
    chk_thresh_kept: assert property (!general_regs_available
        |=> $stable(low_power_current_threshold)) else $error("threshold changed");
    chk_reduced_mav: assert property (power_mode == lpctm_pkg::LPCTM_REDUCED
        |-> mean_abs_enable) else $error("mean value engine off");
    chk_soft_keeps: assert property (soft_reset |=> $stable(low_power_current_threshold)
        && $stable(port_lock_config)) else $error("soft reset lost config");
    chk_done_clear: assert property (s_done_clear |=> !second_status_register[15]
        && current_present_irq_n) else $error("done flag not cleared");
    chk_quiet_src: assert property ($fell(quiet_current_irq_n)
        |-> power_mode == lpctm_pkg::LPCTM_LOW) else $error("quiet irq outside low power");
endmodule // lpctm_monitor_props
bind lpctm_monitor lpctm_monitor_props lpctm_monitor_props_i (
    .mclk(mclk), .rst_b(rst_b), .soft_reset(soft_reset),
    .mode_select_msb(mode_select_msb), .mode_select_lsb(mode_select_lsb),
    .status_write(status_write), .status_wdata(status_wdata),
    .low_power_current_threshold(low_power_current_threshold),
    .port_lock_config(port_lock_config), .second_status_register(second_status_register),
    .quiet_current_irq_n(quiet_current_irq_n), .current_present_irq_n(current_present_irq_n),
    .serial_port_enable(serial_port_enable),
    .high_speed_capture_port_enable(high_speed_capture_port_enable),
    .general_regs_available(general_regs_available), .mean_abs_enable(mean_abs_enable),
    .power_mode(power_mode));
`default_nettype wire

// [lpctm_phase.sv]
`timescale 1ns/1ps
`default_nettype none
// One phase: threshold comparator on the positive terminal and excursion counter
module lpctm_phase #(
    parameter int SAMPLE_W = 16,
    parameter int COUNT_W = 8
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_b,
    // Control
    input wire logic window_start,
    input wire logic sample_valid,
    // Positive terminal sample and threshold
    input wire logic [SAMPLE_W-1:0] positive_sample,
    input wire logic [SAMPLE_W-1:0] threshold,
    // Result
    output logic [COUNT_W-1:0] count
);
    logic above;
    logic next_above;

    // Only the positive terminal is compared, not the differential signal
    assign next_above = positive_sample > threshold;

    // Remember whether the last sample sat above threshold
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            above <= 1'b0;
        end else if (window_start) begin
            above <= 1'b0;
        end else if (sample_valid) begin
            above <= next_above;
        end
    end

    // Count rising crossings only, saturating at the top
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            count <= '0;
        end else if (window_start) begin
            count <= '0;
        end else if (sample_valid && next_above && !above && count != '1) begin
            count <= count + 1'b1;
        end
    end
endmodule // lpctm_phase
`default_nettype wire

// [lpctm_pkg.sv]
package lpctm_pkg;
    // Clock and window timing
    localparam int CLK_HZ = 125000000;
    localparam real WINDOW_UNIT_S = 0.02;
    localparam int WINDOW_UNIT_CYCLES = int'(WINDOW_UNIT_S * CLK_HZ);
    // Threshold register fields
    localparam int LEVEL_LSB = 0;
    localparam int LEVEL_MSB = 2;
    localparam int WINDOW_LSB = 3;
    localparam int WINDOW_MSB = 7;
    localparam logic [2:0] LEVEL_RESET = 3'h7;
    localparam logic [4:0] WINDOW_RESET = 5'h00;
    localparam logic [7:0] THRESHOLD_RESET = {WINDOW_RESET, LEVEL_RESET};
    localparam int LEVEL_DIV_SHIFT = 3;
    // Second status register
    localparam int DONE_BIT = 15;
    // Port lock configuration
    localparam int LOCK_BIT = 1;
    localparam logic [7:0] PORT_LOCK_RESET = 8'h00;
    // Delay from entering normal mode to transition done
    localparam int TRANSITION_CYCLES = 16;
    // Mode pin encoding {msb, lsb}
    localparam logic [1:0] MODE_NORMAL = 2'h1;
    localparam logic [1:0] MODE_REDUCED = 2'h0;
    localparam logic [1:0] MODE_LOW = 2'h2;
    localparam logic [1:0] MODE_SLEEP = 2'h3;
    typedef enum logic [1:0] {
        LPCTM_NORMAL,
        LPCTM_REDUCED,
        LPCTM_LOW,
        LPCTM_SLEEP
    } lpctm_mode_t;
endpackage

// [tb.sv]
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic mclk, rst_b, soft_reset, spi_req, cv, msb, lsb, burst;
    logic qirq_n, pirq_n, spe, spi_sel, hspe, gra, mae, idle;
    logic [2:0] we;
    logic [1:0] cm;
    logic [7:0] thr, lock;
    logic [7:0] cyc = 8'h00;
    logic [15:0] wd, stat;
    logic [15:0] pa = 16'h1000;
    lpctm_pkg::lpctm_mode_t pmode;
    int fails, checks_done, tick, n;
    lpctm_monitor #(.WINDOW_UNIT(20)) lpctm_monitor_i (
        .mclk(mclk), .rst_b(rst_b), .soft_reset(soft_reset),
        .mode_select_msb(msb), .mode_select_lsb(lsb),
        .threshold_write(we[0]), .threshold_wdata(wd[7:0]),
        .port_lock_write(we[1]), .port_lock_wdata(wd[7:0]),
        .status_write(we[2]), .status_wdata(wd), .spi_select_request(spi_req),
        .sample_valid(1'b1), .phase_a_positive_input(pa),
        .phase_b_positive_input(16'h4000), .phase_c_positive_input(16'h0000),
        .full_scale(16'h8000), .low_power_current_threshold(thr),
        .port_lock_config(lock), .second_status_register(stat),
        .quiet_current_irq_n(qirq_n), .current_present_irq_n(pirq_n),
        .serial_port_enable(spe), .spi_selected(spi_sel),
        .high_speed_capture_port_enable(hspe), .general_regs_available(gra),
        .mean_abs_enable(mae), .dsp_idle(idle), .power_mode(pmode));
    lpctm_host lpctm_host_i (
        .mclk(mclk), .rst_b(rst_b), .cmd_valid(cv), .cmd_mode(cm),
        .quiet_current_irq_n(qirq_n), .current_present_irq_n(pirq_n),
        .mode_select_msb(msb), .mode_select_lsb(lsb));
    // Clock
    initial begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end
    // Phase A swings across the threshold while burst is set
    always @(negedge mclk) begin
        cyc <= cyc + 8'h01;
        pa <= (burst && cyc[2]) ? 16'h5000 : 16'h1000;
    end
    // Hang guard
    always @(posedge mclk) begin
        tick = tick + 1;
        if (tick > 3000) begin
            fails = fails + 1;
            tally_and_finish;
        end
    end
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checks_done = checks_done + 1;
        if (seen !== exp) begin
            fails = fails + 1;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input int k, input logic [15:0] d);
        @(negedge mclk);
        we[k] = 1'b1;
        wd = d;
        @(negedge mclk);
        we = 3'h0;
    endtask
    task automatic mode(input logic [1:0] m);
        @(negedge mclk);
        cv = 1'b1;
        cm = m;
        @(negedge mclk);
        cv = 1'b0;
    endtask
    task automatic clear_done;
        wait (!pirq_n);
        @(negedge mclk);
        chk(stat, 16'h8000);
        wr(2, 16'h8000);
        chk(16'({stat[15], pirq_n}), 16'h0001);
    endtask
    task tally_and_finish;
        if (fails == 0 && checks_done > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // Main sequence
    initial begin
        {rst_b, soft_reset, spi_req, cv, burst} = 5'h00;
        {fails, checks_done, tick} = {32'd0, 32'd0, 32'd0};
        cm = 2'h1;
        we = 3'h0;
        wd = 16'h0000;
        repeat (20) @(negedge mclk);
        chk(16'({thr, lock}), 16'h0700);
        chk(stat, 16'h0000);
        chk(16'({idle, spi_sel}), 16'h0002);
        rst_b = 1'b1;
        clear_done;
        wr(0, 16'h000c);
        chk(16'(thr), 16'h000c);
        wr(1, 16'h0002);
        spi_req = 1'b1;
        @(negedge mclk);
        spi_req = 1'b0;
        soft_reset = 1'b1;
        @(negedge mclk);
        soft_reset = 1'b0;
        chk(16'({spi_sel, lock}), 16'h0002);
        chk(16'(thr), 16'h000c);
        clear_done;
        burst = 1'b1;
        mode(2'h2);
        wait (pmode == lpctm_pkg::LPCTM_LOW);
        @(negedge mclk);
        chk(16'({spe, gra}), 16'h0000);
        wr(0, 16'h00ff);
        chk(16'(thr), 16'h000c);
        wait (!pirq_n);
        @(negedge mclk);
        chk(16'(qirq_n), 16'h0001);
        wait (pmode == lpctm_pkg::LPCTM_REDUCED);
        @(negedge mclk);
        chk(16'({mae, spe}), 16'h0003);
        burst = 1'b0;
        mode(2'h2);
        wait (pmode == lpctm_pkg::LPCTM_LOW);
        n = 0;
        while (qirq_n === 1'b1 && n < 200) begin
            @(negedge mclk);
            n = n + 1;
        end
        chk(16'(n >= 39 && n <= 42), 16'h0001);
        chk(16'(pirq_n), 16'h0001);
        wait (pmode == lpctm_pkg::LPCTM_SLEEP);
        @(negedge mclk);
        chk(16'({spe, hspe}), 16'h0000);
        mode(2'h1);
        wait (!pirq_n);
        @(negedge mclk);
        chk(16'({thr, lock}), 16'h0c02);
        // Hardware reset in mid run, then a four-wire choice locked across a soft reset
        rst_b = 1'b0;
        @(negedge mclk);
        chk(16'({thr, lock}), 16'h0700);
        rst_b = 1'b1;
        clear_done;
        spi_req = 1'b1;
        @(negedge mclk);
        spi_req = 1'b0;
        wr(1, 16'h0000);
        soft_reset = 1'b1;
        @(negedge mclk);
        soft_reset = 1'b0;
        chk(16'({spi_sel, lock}), 16'h0100);
        tally_and_finish;
    end
endmodule // tb
`default_nettype wire
